// ---- core/dtc_pkg.sv ----
// Shared constants for the dual 8-bit timer/counter with divider, PWM and cascade modes
package dtc_pkg;

  // ----------------------------------------------------------------
  // Clock rates and prescaler taps
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int SUB_OSC_HZ = 32_768;
  // Sub oscillator is modelled as an enable every SUB_DIV main clocks (rounded down)
  localparam int SUB_DIV = CLK_HZ / SUB_OSC_HZ;
  localparam int SUB_CNT_W = 10;
  localparam int MAIN_DIV_W = 11;
  localparam int EXP_MAIN2 = 1;
  localparam int EXP_MAIN8 = 3;
  localparam int EXP_MAIN32 = 5;
  localparam int EXP_MAIN128 = 7;
  localparam int EXP_MAIN2048 = 11;
  localparam int SUB8_W = 3;
  localparam int NTAPS = 8;
  localparam int TAP_MAIN = 0;
  localparam int TAP_MAIN2 = 1;
  localparam int TAP_MAIN8 = 2;
  localparam int TAP_MAIN32 = 3;
  localparam int TAP_MAIN128 = 4;
  localparam int TAP_MAIN2048 = 5;
  localparam int TAP_SUB = 6;
  localparam int TAP_SUB8 = 7;

  // ----------------------------------------------------------------
  // Channel control register layout
  // ----------------------------------------------------------------
  localparam int NCH = 2;
  localparam int LOWER = 0;
  localparam int UPPER = 1;
  localparam int CR_PRESET_BIT = 7;
  localparam int CR_RUN_BIT = 3;
  localparam int CR_CSEL_LSB = 4;
  localparam int CR_MODE_LSB = 0;
  localparam logic [2:0] MODE_TIMER8 = 3'h0;
  localparam logic [2:0] MODE_DIV = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] MODE_16L = 3'h3;
  localparam logic [2:0] MODE_16H = 3'h4;
  localparam logic [2:0] CS_SLOWEST = 3'h0;
  localparam logic [2:0] CS_MAIN128 = 3'h1;
  localparam logic [2:0] CS_MAIN32 = 3'h2;
  localparam logic [2:0] CS_MAIN8 = 3'h3;
  localparam logic [2:0] CS_SUB = 3'h4;
  localparam logic [2:0] CS_MAIN2 = 3'h5;
  localparam logic [2:0] CS_MAIN = 3'h6;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam int CH_STRIDE = 4;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_DUTY = 8'h10;
  localparam logic [7:0] OFS_CFG = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam int CFG_TAP_BIT = 0;
  localparam int CFG_SLOW_BIT = 1;
  localparam int STAT_PIN_LSB = 16;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [15:0] CNT16_ONE = 16'h0001;

endpackage : dtc_pkg

// ---- core/dtc_prescaler.sv ----
// Prescaler producing one-cycle enable pulses for every source clock tap
`timescale 1ns/1ps
module dtc_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic [dtc_pkg::NTAPS-1:0] tap_o
);
  import dtc_pkg::*;

  logic [MAIN_DIV_W-1:0] main_cnt_r;
  logic [SUB_CNT_W-1:0] sub_cnt_r;
  logic [SUB8_W-1:0] sub8_cnt_r;
  logic [NTAPS-1:0] tap_r;
  wire sub_wrap = sub_cnt_r == SUB_CNT_W'(SUB_DIV - 1);
  wire [NTAPS-1:0] tap_nxt;

  // ----------------------------------------------------------------
  // Tap decode: a main tap fires when the low bits of its divider are all ones; sub taps fire on the sub divider wrap
  // ----------------------------------------------------------------
  assign tap_nxt[TAP_MAIN] = 1'b1;
  assign tap_nxt[TAP_MAIN2] = &main_cnt_r[EXP_MAIN2-1:0];
  assign tap_nxt[TAP_MAIN8] = &main_cnt_r[EXP_MAIN8-1:0];
  assign tap_nxt[TAP_MAIN32] = &main_cnt_r[EXP_MAIN32-1:0];
  assign tap_nxt[TAP_MAIN128] = &main_cnt_r[EXP_MAIN128-1:0];
  assign tap_nxt[TAP_MAIN2048] = &main_cnt_r[EXP_MAIN2048-1:0];
  assign tap_nxt[TAP_SUB] = sub_wrap;
  assign tap_nxt[TAP_SUB8] = sub_wrap & (&sub8_cnt_r);

  // Free-running dividers; the sub clock never stops so its taps stay in phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_cnt_r <= '0;
      sub_cnt_r <= '0;
      sub8_cnt_r <= '0;
      tap_r <= '0;
    end else begin
      main_cnt_r <= main_cnt_r + MAIN_DIV_W'(1);
      sub_cnt_r <= sub_wrap ? '0 : sub_cnt_r + SUB_CNT_W'(1);
      if (sub_wrap) begin
        sub8_cnt_r <= sub8_cnt_r + SUB8_W'(1);
      end
      tap_r <= tap_nxt;
    end
  end

  assign tap_o = tap_r;

endmodule : dtc_prescaler

// ---- core/dtc_timer.sv ----
// Dual 8-bit timer/counter: divider output, 8-bit PWM and cascaded 16-bit timer
//
// What this block does
// - Divider mode gives a 50% duty square wave
// - Divider match toggles flop, clears counter, raises request
// - Divider pin is the inverse of the flop
// - Software presets the flop; reset clears it
// - Period register unbuffered; writes act at once
// - Stopping holds pin; preset only after the stop
// - Control bit 3 runs, bit 7 presets flop
// - 0x11 picks main/128 divider mode; 0x19 starts
// - PWM toggles on duty match and on overflow
// - PWM pin inverts flop; preset picks pulse polarity
// - Running PWM duty write loads at next request
// - Duty read returns the value in use
// - Stopping PWM holds pin; preset after stop
// - PWM adds sub, main/2, main; sub-clock limits taps
// - Upper run bit starts cascaded 16-bit match timer
// - 16-bit mode only uses the four prescaled taps
// - Lower 0x13, upper 0x04 then 0x0C runs cascade
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module dtc_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic [dtc_pkg::NCH-1:0] divider_out_pin_o,
  output logic [dtc_pkg::NCH-1:0] pwm_out_pin_o,
  output logic [dtc_pkg::NCH-1:0] channel_match_irq_o
);
  import dtc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic ack_r;
  logic [31:0] rdat_r;
  logic [1:0] cfg_r;
  logic [NTAPS-1:0] tap;
  logic [31:0] rd_mux;
  wire [8*NCH-1:0] ctrl_v;
  wire [8*NCH-1:0] period_v;
  wire [8*NCH-1:0] duty_v;
  wire [8*NCH-1:0] cnt_v;
  wire [NCH-1:0] pin_v;
  wire [NCH-1:0] tick_v;

  // ----------------------------------------------------------------
  // Source clock selection
  // ----------------------------------------------------------------
  // Unavailable selections give no tick at all, so the counter just stalls
  function automatic logic tick_of(input logic [2:0] csel, input logic pwm, input logic slow,
                                   input logic tap_sel, input logic [NTAPS-1:0] taps);
    logic t;
    t = 1'b0;
    case (csel)
      CS_SLOWEST: t = (tap_sel | slow) ? taps[TAP_SUB8] : taps[TAP_MAIN2048];
      CS_MAIN128: t = ~slow & taps[TAP_MAIN128];
      CS_MAIN32: t = ~slow & taps[TAP_MAIN32];
      CS_MAIN8: t = ~slow & taps[TAP_MAIN8];
      CS_SUB: t = pwm & taps[TAP_SUB];
      CS_MAIN2: t = pwm & ~slow & taps[TAP_MAIN2];
      CS_MAIN: t = pwm & ~slow & taps[TAP_MAIN];
      default: t = 1'b0;
    endcase
    return t;
  endfunction : tick_of

  dtc_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tap_o(tap)
  );

  // ----------------------------------------------------------------
  // Wishbone slave: one wait state, single-cycle ack
  // ----------------------------------------------------------------
  // Gating with ack_r makes ack drop the cycle after it was given
  wire req = cyc_i & stb_i & ~ack_r;
  wire wr_stb = req & we_i & sel_i[0];
  wire rd_stb = req & ~we_i;
  wire wr_cfg = wr_stb & (adr_i == OFS_CFG);
  wire tap_sel = cfg_r[CFG_TAP_BIT];
  wire slow = cfg_r[CFG_SLOW_BIT];

  // ----------------------------------------------------------------
  // Cascade: the upper channel's mode decides, the upper run bit starts both
  // ----------------------------------------------------------------
  wire cascade = ctrl_v[8*UPPER+CR_MODE_LSB +: 3] == MODE_16H;
  wire casc_run = ctrl_v[8*UPPER+CR_RUN_BIT];
  wire casc_tick = casc_run & tick_v[LOWER];
  wire [15:0] cnt16 = {cnt_v[8*UPPER +: 8], cnt_v[8*LOWER +: 8]};
  wire [15:0] inc16 = cnt16 + CNT16_ONE;
  wire [15:0] per16 = {period_v[8*UPPER +: 8], period_v[8*LOWER +: 8]};
  wire hit16 = inc16 == per16;

  // ----------------------------------------------------------------
  // Per-channel counter, compare, output flop and registers
  // ----------------------------------------------------------------
  for (genvar j = 0; j < NCH; j++) begin : g_ch
    localparam logic [7:0] CH_OFS = 8'(j * CH_STRIDE);
    logic [7:0] ctrl_r;
    logic [7:0] period_r;
    logic [7:0] stage_r;
    logic [7:0] duty_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic pin_r;
    logic irq_r;
    logic flip;
    logic ev;

    // Control field decode
    wire [2:0] mode = ctrl_r[CR_MODE_LSB +: 3];
    wire [2:0] csel = ctrl_r[CR_CSEL_LSB +: 3];
    wire is_pwm = mode == MODE_PWM;
    wire is_div = mode == MODE_DIV;
    wire run = cascade ? casc_run : ctrl_r[CR_RUN_BIT];
    wire tick = run & tick_v[j];
    wire [7:0] inc = cnt_r + CNT_ONE;
    // PWM period ends on overflow, other modes on a period match
    wire hit8 = is_pwm ? (cnt_r == CNT_MAX) : (inc == period_r);
    wire duty_hit = is_pwm & (inc == duty_r);

    // Register write decode
    wire wr_ctrl = wr_stb & (adr_i == OFS_CTRL + CH_OFS);
    wire wr_per = wr_stb & (adr_i == OFS_PERIOD + CH_OFS);
    wire wr_duty = wr_stb & (adr_i == OFS_DUTY + CH_OFS);
    // Preset is taken only while the channel was already stopped
    wire preset_ok = wr_ctrl & ~run;

    assign tick_v[j] = tick_of(csel, is_pwm, slow, tap_sel, tap);
    assign ctrl_v[8*j +: 8] = ctrl_r;
    assign period_v[8*j +: 8] = period_r;
    assign duty_v[8*j +: 8] = duty_r;
    assign cnt_v[8*j +: 8] = cnt_r;
    assign pin_v[j] = pin_r;

    // Next counter value and the events of this tick
    always_comb begin
      cnt_nxt = cnt_r;
      flip = 1'b0;
      ev = 1'b0;
      if (!run) begin
        cnt_nxt = '0;
      end else if (cascade) begin
        if (casc_tick) begin
          cnt_nxt = hit16 ? '0 : inc16[8*j +: 8];
          ev = hit16 & (j == UPPER);
        end
      end else if (tick) begin
        cnt_nxt = hit8 ? '0 : inc;
        ev = hit8;
        flip = (is_div & hit8) | (is_pwm & (hit8 ^ duty_hit));
      end
    end

    // Configuration registers; the period is used directly, never staged
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ctrl_r <= CTRL_RST;
        period_r <= PERIOD_RST;
      end else begin
        if (wr_ctrl) begin
          ctrl_r <= dat_i[7:0];
        end
        if (wr_per) begin
          period_r <= dat_i[7:0];
        end
      end
    end

    // Duty staging: a write while running in PWM mode waits for the period end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        stage_r <= DUTY_RST;
        duty_r <= DUTY_RST;
      end else begin
        if (wr_duty) begin
          stage_r <= dat_i[7:0];
        end
        if (wr_duty & ~(run & is_pwm)) begin
          duty_r <= dat_i[7:0];
        end else if (ev & is_pwm) begin
          duty_r <= stage_r;
        end
      end
    end

    // Counter and match request
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_r <= '0;
        irq_r <= 1'b0;
      end else begin
        cnt_r <= cnt_nxt;
        irq_r <= ev;
      end
    end

    // The pin level is kept directly; the flop value is its inverse
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_r <= 1'b1;
      end else if (preset_ok) begin
        pin_r <= ~dat_i[CR_PRESET_BIT];
      end else if (flip) begin
        pin_r <= ~pin_r;
      end
    end

    assign channel_match_irq_o[j] = irq_r;
  end : g_ch

  // ----------------------------------------------------------------
  // Both pins show the inverted flop; stopping leaves them as they were
  // ----------------------------------------------------------------
  assign divider_out_pin_o = pin_v;
  assign pwm_out_pin_o = pin_v;

  // ----------------------------------------------------------------
  // Read mux; unmapped addresses read as zero
  // ----------------------------------------------------------------
  wire [7:0] ch_idx_ofs = adr_i & 8'(CH_STRIDE);
  wire up_sel = ch_idx_ofs != 8'h00;
  wire [7:0] rd_ctrl = up_sel ? ctrl_v[8*UPPER +: 8] : ctrl_v[8*LOWER +: 8];
  wire [7:0] rd_per = up_sel ? period_v[8*UPPER +: 8] : period_v[8*LOWER +: 8];
  wire [7:0] rd_duty = up_sel ? duty_v[8*UPPER +: 8] : duty_v[8*LOWER +: 8];
  wire is_ctrl = (adr_i == OFS_CTRL) | (adr_i == OFS_CTRL + 8'(CH_STRIDE));
  wire is_per = (adr_i == OFS_PERIOD) | (adr_i == OFS_PERIOD + 8'(CH_STRIDE));
  wire is_duty = (adr_i == OFS_DUTY) | (adr_i == OFS_DUTY + 8'(CH_STRIDE));
  wire is_cfg = adr_i == OFS_CFG;
  wire is_stat = adr_i == OFS_STAT;

  always_comb begin
    rd_mux = '0;
    if (is_ctrl) begin
      rd_mux[7:0] = rd_ctrl;
    end else if (is_per) begin
      rd_mux[7:0] = rd_per;
    end else if (is_duty) begin
      rd_mux[7:0] = rd_duty;
    end else if (is_cfg) begin
      rd_mux[1:0] = cfg_r;
    end else if (is_stat) begin
      rd_mux[15:0] = cnt16;
      rd_mux[STAT_PIN_LSB +: NCH] = pin_v;
    end
  end

  // ----------------------------------------------------------------
  // Bus state and the shared configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= '0;
      cfg_r <= CFG_RST;
    end else begin
      ack_r <= req;
      if (rd_stb) begin
        rdat_r <= rd_mux;
      end
      if (wr_cfg) begin
        cfg_r <= dat_i[1:0];
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = rdat_r;

endmodule : dtc_timer

// ---- sim/dtc_timer_monitor.sv ----
// Concurrent checks on the ports of the dual timer
`timescale 1ns/1ps
module dtc_timer_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [1:0] divider_out_pin_o,
  input wire logic [1:0] pwm_out_pin_o,
  input wire logic [1:0] channel_match_irq_o
);
  // ----------------------------------------------------------------
  // Run bits as software last wrote them
  // ----------------------------------------------------------------
  logic [1:0] run_r;
  logic [1:0] run_nxt;
  wire req_w = cyc_i & stb_i & ~ack_o;
  wire wr_w = req_w & we_i & sel_i[0];
  wire [1:0] wctl_w = {wr_w && adr_i == 8'h04, wr_w && adr_i == 8'h00};
  assign run_nxt[0] = wctl_w[0] ? dat_i[3] : run_r[0];
  assign run_nxt[1] = wctl_w[1] ? dat_i[3] : run_r[1];

  // Tracker follows the bus so checks need no view of the internals
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 2'h0;
    end else begin
      run_r <= run_nxt;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  pin_mirror_a: assert property (pwm_out_pin_o == divider_out_pin_o)
    else $error("pwm pins differ from divider pins");
  reset_pins_a: assert property ($past(rst_i) |-> divider_out_pin_o == 2'h3 && channel_match_irq_o == 2'h0)
    else $error("pins not high after reset");
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_next_a: assert property (req_w |=> ack_o)
    else $error("ack missing one cycle after request");
  irq_pulse_a: assert property ((channel_match_irq_o & $past(channel_match_irq_o)) == 2'h0)
    else $error("match request longer than one cycle");
  preset_load_a: assert property (wctl_w[0] && !run_r[0] |=> divider_out_pin_o[0] == !$past(dat_i[7]))
    else $error("preset not applied while stopped");
  stop_hold_a: assert property (wctl_w[0] && run_r[0] && !dat_i[3] |=> ##1 $stable(divider_out_pin_o[0])[*2])
    else $error("pin moved after stop");
  idle_hold_a: assert property (!run_r[0] && !wctl_w[0] |=> $stable(divider_out_pin_o[0]))
    else $error("stopped pin moved");
  low_irq_a: assert property (channel_match_irq_o[0] |-> $past(run_r[0]) || $past(run_r[0], 2))
    else $error("lower request while stopped");
  up_irq_a: assert property (channel_match_irq_o[1] |-> $past(run_r[1]) || $past(run_r[1], 2))
    else $error("upper request while stopped");
  unmapped_zero_a: assert property (req_w && !we_i && adr_i == 8'h40 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (ack_o |-> dat_o[31:18] == 14'h0)
    else $error("unused read bits not zero");
endmodule : dtc_timer_monitor

bind dtc_timer dtc_timer_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
  .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .divider_out_pin_o(divider_out_pin_o), .pwm_out_pin_o(pwm_out_pin_o),
  .channel_match_irq_o(channel_match_irq_o));

// ---- sim/dtc_load.sv ----
// External load seen through the shared port output latch
`timescale 1ns/1ps
module dtc_load (
  input wire logic port_latch_i,
  input wire logic [1:0] pin_i,
  output logic [1:0] level_o
);
  // With the latch cleared the port pulls the pin low whatever the timer does
  assign level_o = port_latch_i ? pin_i : 2'h0;
endmodule : dtc_load

// ---- sim/dtc_timer_bench.sv ----
// Self-checking bench for the dual timer
`timescale 1ns/1ps
module dtc_timer_bench;
  import dtc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic latch = 1'b1;
  wire [31:0] rdat;
  wire ack;
  wire [1:0] dpin;
  wire [1:0] ppin;
  wire [1:0] irq;
  wire [1:0] seen;
  int fail_count = 0;
  int num_checks = 0;
  int lo_hits = 0;
  int n;
  logic [31:0] q;
  logic p;

  always #25 clk_i = ~clk_i;

  dtc_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we),
    .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .divider_out_pin_o(dpin),
    .pwm_out_pin_o(ppin), .channel_match_irq_o(irq));
  dtc_load i_load (.port_latch_i(latch), .pin_i(dpin), .level_o(seen));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Classic single cycle; the request holds until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : wb

  // Returns the cycles until the next request of a channel
  task automatic wait_irq(input int ch, output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
      lo_hits += int'(irq[0] === 1'b1);
    end while (irq[ch] !== 1'b1 && k < 5000);
    if (k >= 5000) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : wait_irq

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(32'(seen), 32'h3);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      chk(q, (i == 2 || i == 3) ? 32'hFF : 32'h0);
    end
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h1C, 32'h0);
    chk(32'(q[17:16]), 32'h3);
    // A cleared port latch holds the load low whatever the timer drives
    latch <= 1'b0;
    @(posedge clk_i);
    chk(32'(seen), 32'h0);
    latch <= 1'b1;
  endtask : t_reset

  // Divider on the lower channel through three prescaler taps
  task automatic t_divider;
    wb(1'b1, 8'h08, 32'h2);
    for (int cs = 1; cs < 4; cs++) begin
      wb(1'b1, 8'h00, 32'(16 * cs + 1));
      wb(1'b1, 8'h00, 32'(16 * cs + 9));
      wait_irq(0, n);
      p = seen[0];
      wait_irq(0, n);
      chk(32'(n), 32'(2 * (128 >> (2 * cs - 2))));
      chk({31'h0, ~p}, 32'h1);
      wb(1'b1, 8'h00, 32'(16 * cs + 1));
    end
    p = seen[0];
    repeat (40) @(posedge clk_i);
    chk(32'(seen[0]), 32'(p));
    wb(1'b1, 8'h00, 32'hB1);
    chk(32'(seen[0]), 32'h0);
    wb(1'b1, 8'h00, 32'h31);
    chk(32'(seen[0]), 32'h1);
  endtask : t_divider

  // PWM on the upper channel with a duty change while running
  task automatic t_pwm;
    wb(1'b1, 8'h14, 32'h40);
    wb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h40);
    wb(1'b1, 8'h04, 32'h6A);
    wait_irq(1, n);
    wb(1'b1, 8'h14, 32'h80);
    wb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h40);
    wait_irq(1, n);
    wait_irq(1, n);
    chk(32'(n), 32'd256);
    wb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h80);
    n = 0;
    repeat (256) begin
      @(posedge clk_i);
      n += int'(ppin[1] === 1'b0);
    end
    chk(32'(n), 32'd128);
    wb(1'b1, 8'h04, 32'h62);
    p = ppin[1];
    repeat (20) @(posedge clk_i);
    chk(32'(ppin[1]), 32'(p));
    wb(1'b1, 8'h04, 32'hE2);
    chk(32'(ppin[1]), 32'h0);
    wb(1'b1, 8'h04, 32'h5A);
    wait_irq(1, n);
    wait_irq(1, n);
    chk(32'(n), 32'd512);
    wb(1'b1, 8'h04, 32'h52);
  endtask : t_pwm

  // Cascaded 16-bit interval on the main/8 tap
  task automatic t_cascade;
    wb(1'b1, 8'h08, 32'h05);
    wb(1'b1, 8'h0C, 32'h01);
    wb(1'b1, 8'h00, 32'h33);
    wb(1'b1, 8'h04, 32'h04);
    wb(1'b1, 8'h04, 32'h0C);
    wait_irq(1, n);
    lo_hits = 0;
    wait_irq(1, n);
    chk(32'(n), 32'd2088);
    chk(32'(lo_hits), 32'h0);
    wb(1'b1, 8'h04, 32'h04);
    wb(1'b0, 8'h1C, 32'h0);
    chk(32'(q[15:0]), 32'h0);
  endtask : t_cascade

  // Sub-clock mode: prescaled main taps die, the slowest select falls back to sub/8
  task automatic t_subclk;
    wb(1'b1, 8'h04, 32'h00);
    wb(1'b1, 8'h18, 32'h2);
    wb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h2);
    wb(1'b1, 8'h08, 32'h01);
    wb(1'b1, 8'h00, 32'h11);
    wb(1'b1, 8'h00, 32'h19);
    // Period 1 would give a request every 128 clocks if the tap still ran
    n = 0;
    repeat (400) begin
      @(posedge clk_i);
      n += int'(irq[0] === 1'b1);
    end
    chk(32'(n), 32'h0);
    wb(1'b1, 8'h00, 32'h01);
    wb(1'b1, 8'h00, 32'h09);
    wait_irq(0, n);
    wait_irq(0, n);
    chk(32'(n), 32'(SUB_DIV << SUB8_W));
    wb(1'b1, 8'h00, 32'h01);
    wb(1'b1, 8'h18, 32'h0);
  endtask : t_subclk

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_divider();
    t_pwm();
    t_cascade();
    t_subclk();
    tally_and_finish();
  end
endmodule : dtc_timer_bench
